// *** line_partner.sv ***
// line-side partner: frame strobes, received s-frames and the sync pin source
// assumes the pclk of the block under test; one frame lasts FRAME_CYCLES cycles
`timescale 1ns/100ps
module line_partner
  import mf_sync_pkg::*;
#(
  parameter int FRAME_CYCLES = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sync_level,
  output logic f_bit_start,
  output logic rx_frame_valid,
  output line_frame_t rx_frame,
  output logic sync_pin
);
  int seed = 32'h3b269c4a;
  logic [4:0] phase;
  logic [4:0] fnum;
  logic [31:0] r;

  // frame timing, multiframe framing bits, sync source
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 5'h00;
      fnum <= 5'h01;
      f_bit_start <= 1'b0;
      rx_frame_valid <= 1'b0;
      rx_frame <= '0;
      sync_pin <= 1'b0;
    end
    else
    begin
      r = $random(seed);
      phase <= (phase == 5'(FRAME_CYCLES - 1)) ? 5'h00 : phase + 5'h01;
      f_bit_start <= (phase == 5'(FRAME_CYCLES - 1));
      rx_frame_valid <= (phase == 5'h05);
      if (phase == 5'h05)
      begin
        rx_frame <= {fnum % 5 == 1, fnum % 5 != 1, fnum == 5'h01, r[17:0]};
        fnum <= (fnum == 5'h14) ? 5'h01 : fnum + 5'h01;
      end
      else
        rx_frame <= ~rx_frame; // stale data toggles so nothing can lean on it
      // sync moves mid-frame, well clear of the f bit sample
      if (phase == 5'h0a)
        sync_pin <= sync_level;
    end
  end
endmodule : line_partner

// *** mf_sync_pkg.sv ***
// shared constants and types of the multiframe sync and channel gating block
// assumes a 32-bit apb master and a line framer on the same pclk
package mf_sync_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SQ_TX = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // transceiver_command_reg field positions
  localparam int MODE_LSB = 0;
  localparam int SEL_BIT = 2;
  localparam int SM_DIS_BIT = 3;
  localparam int TRANSMIT_INFO_SELECT_LSB = 4;
  localparam int TDD_BIT = 7;
  localparam int AR_LSB = 8;
  localparam int DMODE_LSB = 10;
  // sq_transmit_reg_one field positions
  localparam int MULTIFRAME_ENABLE_BIT = 4;
  // reset values
  localparam logic [12:0] CTRL_RESET = 13'h0080;
  localparam logic [4:0] SQ_TX_RESET = 5'h00;
  // multiframe figures
  localparam logic [4:0] MF_LAST = 5'h14;
  localparam logic [4:0] MF_FIRST = 5'h01;
  localparam logic [2:0] TRANSMIT_INFO_SELECT_TRANSPARENT = 3'h3;
  localparam logic [3:0] PRIO_EIGHT = 4'h8;
  localparam logic [3:0] PRIO_TEN = 4'ha;
  localparam logic [1:0] LOCK_COUNT = 2'h2;
  typedef enum logic [1:0] {MODE_TE, MODE_NT, MODE_LT_S, MODE_LT_T} op_mode_t;
  typedef enum logic [1:0] {AR_NONE, AR_PRIO8, AR_PRIO10, AR_LOOP} act_req_t;
  // one received s-frame as delivered by the framer
  typedef struct packed {
    logic fa;
    logic n;
    logic m;
    logic [7:0] b1;
    logic [7:0] b2;
    logic d;
    logic e;
  } line_frame_t;
  // channel bits toward the host frame bus
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic d;
    logic e;
  } host_chan_t;
endpackage : mf_sync_pkg

// *** s_bus_multiframe_sync.sv ***
// multiframe alignment, sync pin handling and line-to-host channel gating
// assumes one pclk, frame strobes from the framer on pclk, pins asynchronous
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

// Overview of operation
// - select bit turns pin into sync pin
// - pin direction follows operating mode
// - nt/lt-s sync input needs multiframe enable
// - sample sync input at each f bit
// - sync one forces frame 20, zero bits
// - sync zero counts frames from one
// - single zero frame reaches frame one
// - te/lt-t drive pin with received m
// - te passes b1 b2 d e transparently
// - nt/lt-s passes b1 b2 d transparently
// - otherwise host channels read all ones
// - transmit needs activation request or enable
// - fixed d delay only without stop/go
// - lt-t frame alignment is flexible
// - nt host handler may block d
// - level detector reports during loops
// - te lock after two good multiframes
// - nt generates multiframes only when enabled
module s_bus_multiframe_sync
  import mf_sync_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic f_bit_start,
  input wire logic rx_frame_valid,
  input wire line_frame_t rx_frame,
  input wire logic activated_state,
  input wire logic d_block,
  input wire logic level_detect_pin,
  input wire logic auxiliary_pin_four_in,
  output logic auxiliary_pin_four_out,
  output logic auxiliary_pin_four_oe,
  input wire logic [7:0] gpio_out,
  input wire logic gpio_oe,
  output host_chan_t host_chan,
  output logic host_valid,
  output logic tx_fa,
  output logic tx_m,
  output logic tx_s,
  output logic tx_transparent,
  output logic tx_d_allowed,
  output logic fixed_alignment
);
  logic [12:0] ctrl;
  logic [4:0] sq_tx;
  op_mode_t mode;
  act_req_t act_req;
  logic sel, sm_dis, tdd, multiframe_enable, in_mode, transparent;
  logic [2:0] transmit_info_select, dmode;
  logic [4:0] mf_count, rx_count;
  logic [1:0] good_cnt, bad_cnt;
  logic locked, rx_err, prev_bad;
  logic [1:0] pin_sync, lvl_sync;
  logic [3:0] echo_run;
  logic apb_wr, apb_rd_hit;

  assign mode = op_mode_t'(ctrl[MODE_LSB +: 2]);
  assign sel = ctrl[SEL_BIT];
  assign sm_dis = ctrl[SM_DIS_BIT];
  assign transmit_info_select = ctrl[TRANSMIT_INFO_SELECT_LSB +: 3];
  assign tdd = ctrl[TDD_BIT];
  assign act_req = act_req_t'(ctrl[AR_LSB +: 2]);
  assign dmode = ctrl[DMODE_LSB +: 3];
  assign multiframe_enable = sq_tx[MULTIFRAME_ENABLE_BIT];
  assign in_mode = (mode == MODE_NT) || (mode == MODE_LT_S);
  assign transparent = activated_state || (sm_dis && transmit_info_select == TRANSMIT_INFO_SELECT_TRANSPARENT);
  assign apb_wr = psel && penable && pready && pwrite;
  assign apb_rd_hit = paddr == ADDR_CTRL || paddr == ADDR_SQ_TX || paddr == ADDR_STATUS;

  // apb answer one wait state after the access phase opens
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !apb_rd_hit;
      if (psel && penable && !pready && !pwrite)
      begin
        case (paddr)
          ADDR_CTRL: prdata <= {19'h0, ctrl};
          ADDR_SQ_TX: prdata <= {27'h0, sq_tx};
          ADDR_STATUS: prdata <= {23'h0, lvl_sync[1], locked, tx_transparent, mf_count, transparent};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // register writes land on the completing edge only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CTRL_RESET;
      sq_tx <= SQ_TX_RESET;
    end
    else if (apb_wr && paddr == ADDR_CTRL)
      ctrl <= pwdata[12:0];
    else if (apb_wr && paddr == ADDR_SQ_TX)
      sq_tx <= pwdata[4:0];
  end

  // two-flop synchronisers for the pin and the level detector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_sync <= 2'h0;
      lvl_sync <= 2'h0;
    end
    else
    begin
      pin_sync <= {pin_sync[0], auxiliary_pin_four_in};
      lvl_sync <= {lvl_sync[0], level_detect_pin};
    end
  end

  // multiframe counter, one step per f bit; sync pin high in nt/lt-s with select set pins it at frame 20
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mf_count <= MF_LAST;
    else if (f_bit_start)
    begin
      if (in_mode && !multiframe_enable)
        mf_count <= MF_LAST;
      else if (in_mode && sel && pin_sync[1])
        mf_count <= MF_LAST;
      else if (mf_count == MF_LAST)
        mf_count <= MF_FIRST;
      else
        mf_count <= mf_count + 5'h01;
    end
  end

  // framing bits follow the counter; frame 20 sends all zeros
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_fa <= 1'b0;
      tx_m <= 1'b0;
      tx_s <= 1'b0;
    end
    else if (f_bit_start)
    begin
      if ((in_mode && !multiframe_enable) || (in_mode && sel && pin_sync[1]) || mf_count != MF_LAST && mf_count != 5'h05
          && mf_count != 5'h0a && mf_count != 5'h0f)
      begin
        tx_fa <= 1'b0;
        tx_m <= 1'b0;
        tx_s <= 1'b0;
      end
      else
      begin
        tx_fa <= 1'b1;
        tx_m <= mf_count == MF_LAST;
        tx_s <= sq_tx[mf_count / 5'h05 == 5'h04 ? 0 : (mf_count / 5'h05)];
      end
    end
  end

  // sync pin: output mirrors received m in te/lt-t, released as input in nt/lt-s
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      auxiliary_pin_four_out <= 1'b0;
      auxiliary_pin_four_oe <= 1'b0;
    end
    else if (!sel)
    begin
      auxiliary_pin_four_out <= gpio_out[3]; // general i/o when not selected
      auxiliary_pin_four_oe <= gpio_oe;
    end
    else
    begin
      auxiliary_pin_four_oe <= !in_mode;
      // updated once per frame so a falling-edge sample sees a steady level
      if (!in_mode && rx_frame_valid)
        auxiliary_pin_four_out <= rx_frame.m;
    end
  end

  // te receive multiframe check against the expected fa/n and m pattern
  assign rx_err = (rx_frame.n == rx_frame.fa)
                  || (rx_frame.m != (rx_count == MF_FIRST))
                  || (rx_frame.fa != (rx_count == 5'h01 || rx_count == 5'h06 || rx_count == 5'h0b
                                      || rx_count == 5'h10));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_count <= MF_FIRST;
      good_cnt <= 2'h0;
      bad_cnt <= 2'h0;
      prev_bad <= 1'b0;
      locked <= 1'b0;
    end
    else if (mode != MODE_TE || !multiframe_enable)
    begin
      good_cnt <= 2'h0;
      bad_cnt <= 2'h0;
      prev_bad <= 1'b0;
      locked <= 1'b0;
    end
    else if (rx_frame_valid)
    begin
      rx_count <= rx_frame.m ? 5'h02 : (rx_count == MF_LAST ? MF_FIRST : rx_count + 5'h01);
      if (rx_count == MF_LAST)
      begin
        // a multiframe ends: judge it, two in a row decide
        if (prev_bad || rx_err)
        begin
          good_cnt <= 2'h0;
          bad_cnt <= bad_cnt == LOCK_COUNT ? bad_cnt : bad_cnt + 2'h1;
          if (bad_cnt + 2'h1 >= LOCK_COUNT)
            locked <= 1'b0;
        end
        else
        begin
          bad_cnt <= 2'h0;
          good_cnt <= good_cnt == LOCK_COUNT ? good_cnt : good_cnt + 2'h1;
          if (good_cnt + 2'h1 >= LOCK_COUNT)
            locked <= 1'b1;
        end
        prev_bad <= 1'b0;
      end
      else if (rx_err)
        prev_bad <= 1'b1;
    end
  end

  // channel gating toward the host bus; closed gate shows all ones
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      host_chan <= '1;
      host_valid <= 1'b0;
    end
    else
    begin
      host_valid <= rx_frame_valid;
      if (rx_frame_valid)
      begin
        if (transparent)
          host_chan <= {rx_frame.b1, rx_frame.b2, rx_frame.d, mode == MODE_TE ? rx_frame.e : 1'b1};
        else
          host_chan <= '1;
      end
    end
  end

  // consecutive echo ones for stop/go d access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      echo_run <= 4'h0;
    else if (rx_frame_valid)
      echo_run <= !rx_frame.e ? 4'h0 : (echo_run == 4'hf ? echo_run : echo_run + 4'h1);
  end

  // transmit enables; stop/go holds d until the priority count is seen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_transparent <= 1'b0;
      tx_d_allowed <= 1'b0;
      fixed_alignment <= 1'b1;
    end
    else
    begin
      tx_transparent <= transparent && (sm_dis ? !tdd : act_req != AR_NONE);
      if (in_mode)
        tx_d_allowed <= !d_block;
      else if (dmode[0])
        tx_d_allowed <= echo_run >= (act_req == AR_PRIO10 ? PRIO_TEN : PRIO_EIGHT);
      else
        tx_d_allowed <= 1'b1;
      fixed_alignment <= mode != MODE_LT_T;
    end
  end

  property p_force_twenty;
    @(posedge pclk) disable iff (!presetn)
    f_bit_start && in_mode && multiframe_enable && sel && pin_sync[1] |=> mf_count == MF_LAST && !tx_fa && !tx_m && !tx_s;
  endproperty
  a_force_twenty: assert property (p_force_twenty) else $error("sync high did not force frame 20");

  property p_wrap_one;
    @(posedge pclk) disable iff (!presetn)
    f_bit_start && mf_count == MF_LAST && !(in_mode && (!multiframe_enable || (sel && pin_sync[1]))) |=> mf_count == MF_FIRST;
  endproperty
  a_wrap_one: assert property (p_wrap_one) else $error("counter did not wrap to frame 1");

  property p_frame_one_bits;
    @(posedge pclk) disable iff (!presetn)
    f_bit_start ##1 mf_count == MF_FIRST |-> tx_fa && tx_m;
  endproperty
  a_frame_one_bits: assert property (p_frame_one_bits) else $error("frame 1 lacks fa and m ones");

  property p_hold_between;
    @(posedge pclk) disable iff (!presetn)
    !f_bit_start |=> $stable(mf_count);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("counter moved without an f bit");

  property p_pin_dir;
    @(posedge pclk) disable iff (!presetn)
    sel ##1 sel && $stable(mode) |-> auxiliary_pin_four_oe == !in_mode;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("sync pin direction wrong for mode");

  property p_m_mirror;
    @(posedge pclk) disable iff (!presetn)
    sel && !in_mode && rx_frame_valid ##1 sel |-> auxiliary_pin_four_out == $past(rx_frame.m);
  endproperty
  a_m_mirror: assert property (p_m_mirror) else $error("sync pin output not received m");

  property p_ones_closed;
    @(posedge pclk) disable iff (!presetn)
    rx_frame_valid && !transparent |=> host_chan == '1;
  endproperty
  a_ones_closed: assert property (p_ones_closed) else $error("closed gate did not give all ones");

  property p_nt_no_echo;
    @(posedge pclk) disable iff (!presetn)
    rx_frame_valid && in_mode |=> host_chan.e;
  endproperty
  a_nt_no_echo: assert property (p_nt_no_echo) else $error("echo passed outside te mode");

  property p_tx_gate;
    @(posedge pclk) disable iff (!presetn)
    !activated_state && !sm_dis |=> !tx_transparent;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("transmit opened while not activated");

  property p_no_mf_disabled;
    @(posedge pclk) disable iff (!presetn)
    f_bit_start && in_mode && !multiframe_enable |=> mf_count == MF_LAST ##0 !tx_m;
  endproperty
  a_no_mf_disabled: assert property (p_no_mf_disabled) else $error("multiframe generated while disabled");
endmodule : s_bus_multiframe_sync

// *** tb_top.sv ***
// self-checking bench: apb registers, sync pin, multiframe count, host gating
// assumes line_partner frames of 16 pclk cycles and one apb wait state
`timescale 1ns/100ps
module tb_top
  import mf_sync_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, gpio_out = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic pready, pslverr, err, f_bit_start, rx_frame_valid, pin_out, pin_oe, sync_pin;
  logic activated_state = 1'b0, d_block = 1'b0, level_detect_pin = 1'b0, gpio_oe = 1'b0, sync_level = 1'b1;
  logic host_valid, tx_fa, tx_m, tx_s, tx_transparent, tx_d_allowed, fixed_alignment;
  logic chk_gate = 1'b0, sel = 1'b0, trans_cfg = 1'b0, blk_q = 1'b0, vld_q = 1'b0;
  line_frame_t rx_frame, seen;
  host_chan_t host_chan;
  op_mode_t md = MODE_TE;
  int fails = 0, total_checks = 0, seed = 32'h3b269c4a;
  wire logic aux_level;

  // pin level from whichever side drives it
  assign aux_level = pin_oe ? pin_out : sync_pin;

  initial
  begin
    forever #20 pclk = ~pclk;
  end

  s_bus_multiframe_sync u_s_bus_multiframe_sync (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .f_bit_start(f_bit_start),
    .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame), .activated_state(activated_state), .d_block(d_block),
    .level_detect_pin(level_detect_pin), .auxiliary_pin_four_in(aux_level), .auxiliary_pin_four_out(pin_out),
    .auxiliary_pin_four_oe(pin_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .host_chan(host_chan),
    .host_valid(host_valid), .tx_fa(tx_fa), .tx_m(tx_m), .tx_s(tx_s), .tx_transparent(tx_transparent),
    .tx_d_allowed(tx_d_allowed), .fixed_alignment(fixed_alignment));

  line_partner u_line_partner (
    .pclk(pclk), .presetn(presetn), .sync_level(sync_level), .f_bit_start(f_bit_start),
    .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame), .sync_pin(sync_pin));

  task automatic give_verdict;
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    check(32'(n < 16), 32'h1, "pready wait");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask, input logic e);
    apb(1'b0, a, 32'h0);
    check(rd & mask, exp, "read data");
    check(32'(err), 32'(e), "slave error");
  endtask : rd_chk

  task automatic wait_frames(input int n);
    repeat (n) @(posedge pclk iff f_bit_start);
    repeat (4) @(posedge pclk);
  endtask : wait_frames

  // gate checks off while the setup changes under a frame
  task automatic cfg(input op_mode_t m, input logic s, input logic sm, input logic [2:0] xi, input logic tdd,
                     input act_req_t ar);
    chk_gate <= 1'b0;
    apb(1'b1, ADDR_CTRL, {22'h0, ar, tdd, xi, sm, s, m});
    md = m;
    sel = s;
    trans_cfg = sm && xi == TRANSMIT_INFO_SELECT_TRANSPARENT;
    wait_frames(1);
    chk_gate <= 1'b1;
  endtask : cfg

  // counter value from status, framing bits where the s bit is known
  task automatic tx_chk(input logic [4:0] f);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(32'(rd[5:1]), 32'(f), "frame number");
    check({tx_fa, tx_m, tx_s & (f % 5 == 1 || f == 20)}, {f % 5 == 1, f == 1, f % 5 == 1}, "fa m s");
  endtask : tx_chk

  function automatic host_chan_t exp_chan(line_frame_t f, logic tr);
    host_chan_t h;
    h = '1;
    if (tr)
      h = {f.b1, f.b2, f.d, md == MODE_TE ? f.e : 1'b1};
    return h;
  endfunction : exp_chan

  // host channels and sync pin output, one cycle after each frame
  always @(posedge pclk)
  begin
    if (presetn)
      check(32'(host_valid), 32'(vld_q), "host valid");
    vld_q = rx_frame_valid;
    if (rx_frame_valid)
      seen = rx_frame;
    if (host_valid && chk_gate && md != MODE_LT_T)
    begin
      check(32'(host_chan), 32'(exp_chan(seen, activated_state | trans_cfg)), "host chan");
      if (sel && md == MODE_TE)
        check(32'(aux_level), 32'(seen.m), "sync pin out");
    end
  end

  // random d blocking; only nt and lt-s let the handler block, stop/go is off
  always @(posedge pclk)
  begin
    if (chk_gate)
      check(32'(tx_d_allowed), 32'((md == MODE_NT || md == MODE_LT_S) ? !blk_q : 1'b1), "d access");
    blk_q = d_block;
    d_block <= 1'($random(seed));
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    give_verdict();
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, unmapped slot, random write and readback
    rd_chk(ADDR_CTRL, 32'(CTRL_RESET), 32'h1fff, 1'b0);
    rd_chk(ADDR_SQ_TX, 32'(SQ_TX_RESET), 32'h1f, 1'b0);
    rd_chk(8'h0c, 32'h0, 32'hffffffff, 1'b1);
    v = $random(seed);
    apb(1'b1, ADDR_CTRL, v);
    rd_chk(ADDR_CTRL, v & 32'h1fff, 32'h1fff, 1'b0);
    // gating in te, nt and lt-s, per layer-1 state
    for (int i = 0; i < 6; i++)
    begin
      activated_state <= i[0];
      cfg(op_mode_t'(i >> 1), 1'b0, 1'b0, 3'h0, 1'b1, AR_NONE);
      wait_frames(3);
    end
    // state machine off: info select and transmit disable
    activated_state <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      cfg(MODE_TE, 1'b0, 1'b1, k == 0 ? 3'h2 : 3'h3, k == 2, AR_NONE);
      check(32'(tx_transparent), 32'(k == 1), "tx transparent");
      wait_frames(2);
    end
    activated_state <= 1'b1;
    for (int a = 0; a < 4; a++)
    begin
      cfg(MODE_TE, 1'b0, 1'b0, 3'h0, 1'b1, act_req_t'(a));
      check(32'(tx_transparent), 32'(a != 0), "tx transparent");
    end
    // pin function, direction and alignment per mode
    for (int i = 0; i < 4; i++)
    begin
      cfg(op_mode_t'(i), 1'b1, 1'b0, 3'h0, 1'b1, AR_NONE);
      check(32'(pin_oe), 32'(i == 0 || i == 3), "pin direction");
      check(32'(fixed_alignment), 32'(i != 3), "alignment");
      cfg(op_mode_t'(i), 1'b0, 1'b0, 3'h0, 1'b1, AR_NONE);
      v = $random(seed);
      gpio_out <= v[7:0];
      gpio_oe <= v[8];
      repeat (3) @(posedge pclk);
      check({pin_oe, pin_out}, {gpio_oe, gpio_out[3]}, "gpio drive");
    end
    // nt: sync pin holds, releases and re-forces the counter
    apb(1'b1, ADDR_SQ_TX, 32'h1f);
    cfg(MODE_NT, 1'b1, 1'b0, 3'h0, 1'b1, AR_NONE);
    wait_frames(2);
    sync_level <= 1'b0;
    tx_chk(5'h14);
    for (int k = 1; k < 23; k++)
    begin
      wait_frames(1);
      tx_chk(5'(k > 20 ? k - 20 : k));
    end
    sync_level <= 1'b1;
    wait_frames(2);
    tx_chk(5'h14);
    apb(1'b1, ADDR_SQ_TX, 32'h0f);
    sync_level <= 1'b0;
    wait_frames(3);
    tx_chk(5'h14);
    // level detector seen in status
    level_detect_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(ADDR_STATUS, 32'h100, 32'h100, 1'b0);
    // te follows line m on the pin and locks after two multiframes
    apb(1'b1, ADDR_SQ_TX, 32'h10);
    cfg(MODE_TE, 1'b1, 1'b0, 3'h0, 1'b1, AR_PRIO8);
    wait_frames(100);
    rd_chk(ADDR_STATUS, 32'h80, 32'h80, 1'b0);
    give_verdict();
  end
endmodule : tb_top
